// [include/ecfg_cfg.svh]
// constants of the configuration loader and wake output generator
// assumes a byte-wide memory with one-cycle read latency
// Notes on behaviour
// - with wake enabled, pin and filter events assert the wake output; packet, dest match, link change only with flag bits 1, 0, 2 set
// - wake disabled means no wake output; mode, length, polarity ignored
// - mode bit 6 picks a sustained level (0) or a single pulse (1)
// - length bit 5 picks 1.5 ms (0) or 150 ms (1) pulse
// - pulse timed from first event; later events never stretch or restart it
// - polarity bit 4: 0 active low, 1 active high, both modes
// - device descriptor length/offset pairs read at 35h..3Ch, length first
// - interface string offset 2Eh, object store length 2Fh, offset 30h
// - filter 0 image length at 3Dh, offset 3Eh, length must be 20
// - first four image bytes to filter config, next sixteen to byte mask
// - test bus length at 41h, offset 42h, length must be 4
// - software descriptor length 46h, offset 47h, GPIO 48h-4Fh, LEDs 58h-59h
// - bit 3 picks open-drain (0) or push-pull (1); ignored when disabled
`ifndef ECFG_CFG_SVH
`define ECFG_CFG_SVH
`define ECFG_FLAGS_ADDR   9'h009
`define ECFG_TBL_BASE     9'h02E
`define ECFG_TBL_N        44
`define ECFG_TBL_LAST     6'h2B
`define ECFG_OFF_WUF_LEN  9'h03D
`define ECFG_OFF_WUF_PTR  9'h03E
`define ECFG_OFF_TB_LEN   9'h041
`define ECFG_OFF_TB_PTR   9'h042
`define ECFG_WUF_LEN      8'h14
`define ECFG_WUF_LAST     6'h13
`define ECFG_TB_LEN       8'h04
`define ECFG_TB_LAST      6'h03
`define ECFG_B_EN         7
`define ECFG_B_MODE       6
`define ECFG_B_LEN        5
`define ECFG_B_POL        4
`define ECFG_B_DRV        3
`define ECFG_B_LINK       2
`define ECFG_B_PKT        1
`define ECFG_B_DA         0
`define ECFG_CLK_NS       50
`define ECFG_SHORT_NS     1500000
`define ECFG_LONG_NS      150000000
`define ECFG_R_CTRL       4'h0
`define ECFG_R_STATUS     4'h1
`define ECFG_R_IST        4'h2
`define ECFG_R_IMSK       4'h3
`define ECFG_R_FLAGS      4'h4
`define ECFG_R_FCFG       4'h5
`define ECFG_R_FMSK0      4'h6
`define ECFG_R_FMSK3      4'h9
`define ECFG_R_TBUS       4'hA
`define ECFG_R_TSEL       4'hB
`define ECFG_R_TDATA      4'hC
`define ECFG_C_LOAD       0
`define ECFG_C_WCLR       1
`define ECFG_I_DONE       0
`define ECFG_I_LERR       1
`define ECFG_I_WAKE       2
`endif

// [include/ecfg_pkg.sv]
// types of the configuration loader
// no assumptions beyond the constants header
`default_nettype none
package ecfg_pkg;
  typedef enum logic [2:0] {
    ECFG_S_IDLE = 3'b000,
    ECFG_S_RD   = 3'b001,
    ECFG_S_CAP  = 3'b010,
    ECFG_S_FILT = 3'b011,
    ECFG_S_TB   = 3'b100,
    ECFG_S_DONE = 3'b101
  } ecfg_state_t;
  typedef enum logic [1:0] {
    ECFG_P_FLAGS = 2'b00,
    ECFG_P_TBL   = 2'b01,
    ECFG_P_FILT  = 2'b10,
    ECFG_P_TB    = 2'b11
  } ecfg_phase_t;
endpackage
`default_nettype wire

// [logic/ecfg_loader.sv]
// configuration memory loader with wake output generator
// memory data valid the cycle after MEM_RD_O; events synchronous to CLK_I
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ecfg_cfg.svh"
module ecfg_loader
  import ecfg_pkg::*;
#(
  parameter int AW        = 9,
  parameter int CW        = 22,
  parameter int SHORT_CYC = `ECFG_SHORT_NS / `ECFG_CLK_NS,
  parameter int LONG_CYC  = `ECFG_LONG_NS / `ECFG_CLK_NS
)(
  input  wire logic          CLK_I,
  input  wire logic          RESET_I,
  output logic [AW-1:0]      MEM_ADDR_O,
  output logic               MEM_RD_O,
  input  wire logic [7:0]    MEM_DATA_I,
  input  wire logic [3:0]    REG_ADDR_I,
  input  wire logic [31:0]   REG_WDATA_I,
  input  wire logic          REG_WR_I,
  input  wire logic          REG_RD_I,
  output logic [31:0]        REG_RDATA_O,
  input  wire logic          WAKE_PIN_EVT_I,
  input  wire logic          PACKET_EVT_I,
  input  wire logic          WAKE_FILTER_EVT_I,
  input  wire logic          DEST_ADDR_MATCH_I,
  input  wire logic          LINK_CHANGE_EVT_I,
  output logic               WAKE_OUT_O,
  output logic               WAKE_OUT_OE_O,
  output logic [31:0]        FILT_CFG_O,
  output logic [127:0]       FILT_MASK_O,
  output logic [31:0]        TEST_BUS_O,
  output logic               LOAD_DONE_O,
  output logic               IRQ_O
);
  localparam logic [CW-1:0] SHORT_LD = CW'(SHORT_CYC - 1);
  localparam logic [CW-1:0] LONG_LD  = CW'(LONG_CYC - 1);

  typedef struct packed {
    ecfg_state_t             st;
    ecfg_phase_t             ph;
    logic [AW-1:0]           addr;
    logic [5:0]              cnt;
    logic                    pend;
    logic [7:0]              flags;
    logic [`ECFG_TBL_N-1:0][7:0] tbl;
    logic [19:0][7:0]        fimg;
    logic [3:0][7:0]         tbus;
    logic [5:0]              tsel;
    logic                    done;
    logic                    lerr;
    logic [2:0]              ist;
    logic [2:0]              imsk;
    logic                    on;
    logic [CW-1:0]           pcnt;
    logic [31:0]             rdata;
  } ecfg_regs_t;

  ecfg_regs_t r_reg;
  ecfg_regs_t r_next;
  logic       en;
  logic       pulse;
  logic       evt;
  logic       wr_ctrl;
  logic       out_lvl;

  // table byte at an absolute memory offset
  function automatic logic [7:0] tbl_at(input logic [`ECFG_TBL_N-1:0][7:0] t,
                                        input logic [AW-1:0] off);
    logic [AW-1:0] i;
    i = off - `ECFG_TBL_BASE;
    return t[i];
  endfunction

  function automatic logic [31:0] fword(input logic [19:0][7:0] f, input int b);
    return {f[b+3], f[b+2], f[b+1], f[b]};
  endfunction

  assign en      = r_reg.flags[`ECFG_B_EN];
  assign pulse   = r_reg.flags[`ECFG_B_MODE];
  assign wr_ctrl = REG_WR_I && (REG_ADDR_I == `ECFG_R_CTRL);
  assign evt     = en && (WAKE_PIN_EVT_I || WAKE_FILTER_EVT_I
                   || (PACKET_EVT_I && r_reg.flags[`ECFG_B_PKT])
                   || (DEST_ADDR_MATCH_I && r_reg.flags[`ECFG_B_DA])
                   || (LINK_CHANGE_EVT_I && r_reg.flags[`ECFG_B_LINK]));

  always_comb
  begin
    r_next = r_reg;
    r_next.rdata = 32'h0000_0000;
    // register writes; clears come before hardware sets
    if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        `ECFG_R_CTRL:  r_next.pend = r_reg.pend | REG_WDATA_I[`ECFG_C_LOAD];
        `ECFG_R_IST:   r_next.ist = r_reg.ist & ~REG_WDATA_I[2:0];
        `ECFG_R_IMSK:  r_next.imsk = REG_WDATA_I[2:0];
        `ECFG_R_FLAGS: r_next.flags = REG_WDATA_I[7:0];
        `ECFG_R_TSEL:  r_next.tsel = REG_WDATA_I[5:0];
        default:       r_next.pend = r_reg.pend;
      endcase
    end
    if (REG_RD_I)
    begin
      if (REG_ADDR_I >= `ECFG_R_FMSK0 && REG_ADDR_I <= `ECFG_R_FMSK3)
        r_next.rdata = fword(r_reg.fimg, 4 + 4 * int'(REG_ADDR_I - `ECFG_R_FMSK0));
      else
      begin
        unique case (REG_ADDR_I)
          `ECFG_R_CTRL:   r_next.rdata = {31'h0000_0000, r_reg.pend};
          `ECFG_R_STATUS: r_next.rdata = {28'h000_0000, r_reg.on, r_reg.lerr,
                                          r_reg.st != ECFG_S_IDLE, r_reg.done};
          `ECFG_R_IST:    r_next.rdata = {29'h0000_0000, r_reg.ist};
          `ECFG_R_IMSK:   r_next.rdata = {29'h0000_0000, r_reg.imsk};
          `ECFG_R_FLAGS:  r_next.rdata = {24'h00_0000, r_reg.flags};
          `ECFG_R_FCFG:   r_next.rdata = fword(r_reg.fimg, 0);
          `ECFG_R_TBUS:   r_next.rdata = r_reg.tbus;
          `ECFG_R_TSEL:   r_next.rdata = {26'h000_0000, r_reg.tsel};
          `ECFG_R_TDATA:  r_next.rdata = {24'h00_0000, r_reg.tbl[r_reg.tsel]};
          default:        r_next.rdata = 32'h0000_0000;
        endcase
      end
    end
    // loader sequence
    unique case (r_reg.st)
      ECFG_S_IDLE:
        if (r_reg.pend)
        begin
          r_next.pend = 1'b0;
          r_next.done = 1'b0;
          r_next.lerr = 1'b0;
          r_next.ph   = ECFG_P_FLAGS;
          r_next.addr = AW'(`ECFG_FLAGS_ADDR);
          r_next.st   = ECFG_S_RD;
        end
      ECFG_S_RD:
        r_next.st = ECFG_S_CAP;
      ECFG_S_CAP:
      begin
        r_next.addr = r_reg.addr + AW'(1);
        r_next.cnt  = r_reg.cnt + 6'h01;
        r_next.st   = ECFG_S_RD;
        unique case (r_reg.ph)
          ECFG_P_FLAGS:
          begin
            r_next.flags = MEM_DATA_I;
            r_next.ph    = ECFG_P_TBL;
            r_next.addr  = AW'(`ECFG_TBL_BASE);
            r_next.cnt   = 6'h00;
          end
          ECFG_P_TBL:
          begin
            r_next.tbl[r_reg.cnt] = MEM_DATA_I;
            if (r_reg.cnt == `ECFG_TBL_LAST)
              r_next.st = ECFG_S_FILT;
          end
          ECFG_P_FILT:
          begin
            r_next.fimg[r_reg.cnt[4:0]] = MEM_DATA_I;
            if (r_reg.cnt == `ECFG_WUF_LAST)
              r_next.st = ECFG_S_TB;
          end
          ECFG_P_TB:
          begin
            r_next.tbus[r_reg.cnt[1:0]] = MEM_DATA_I;
            if (r_reg.cnt == `ECFG_TB_LAST)
              r_next.st = ECFG_S_DONE;
          end
        endcase
      end
      ECFG_S_FILT:
      begin
        r_next.cnt = 6'h00;
        r_next.st  = ECFG_S_TB;
        if (tbl_at(r_reg.tbl, `ECFG_OFF_WUF_LEN) == `ECFG_WUF_LEN)
        begin
          r_next.ph   = ECFG_P_FILT;
          r_next.addr = AW'({tbl_at(r_reg.tbl, `ECFG_OFF_WUF_PTR), 1'b0});
          r_next.st   = ECFG_S_RD;
        end
        else if (tbl_at(r_reg.tbl, `ECFG_OFF_WUF_LEN) != 8'h00)
          r_next.lerr = 1'b1;
      end
      ECFG_S_TB:
      begin
        r_next.cnt = 6'h00;
        r_next.st  = ECFG_S_DONE;
        if (tbl_at(r_reg.tbl, `ECFG_OFF_TB_LEN) == `ECFG_TB_LEN)
        begin
          r_next.ph   = ECFG_P_TB;
          r_next.addr = AW'({tbl_at(r_reg.tbl, `ECFG_OFF_TB_PTR), 1'b0});
          r_next.st   = ECFG_S_RD;
        end
        else if (tbl_at(r_reg.tbl, `ECFG_OFF_TB_LEN) != 8'h00)
          r_next.lerr = 1'b1;
      end
      ECFG_S_DONE:
      begin
        r_next.done = 1'b1;
        r_next.st   = ECFG_S_IDLE;
        r_next.ist[`ECFG_I_DONE] = 1'b1;
        r_next.ist[`ECFG_I_LERR] = r_next.ist[`ECFG_I_LERR] | r_reg.lerr;
      end
      default:
        r_next.st = ECFG_S_IDLE;
    endcase
    // wake output generator
    if (!r_next.flags[`ECFG_B_EN])
      r_next.on = 1'b0;
    else if (r_reg.on)
    begin
      if (pulse)
      begin
        if (r_reg.pcnt == {CW{1'b0}})
          r_next.on = 1'b0;
        else
          r_next.pcnt = r_reg.pcnt - CW'(1);
      end
      else if (wr_ctrl && REG_WDATA_I[`ECFG_C_WCLR])
        r_next.on = evt;
    end
    else if (evt)
    begin
      r_next.on   = 1'b1;
      r_next.pcnt = r_reg.flags[`ECFG_B_LEN] ? LONG_LD : SHORT_LD;
      r_next.ist[`ECFG_I_WAKE] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      r_reg      <= '0;
      r_reg.st   <= ECFG_S_IDLE;
      r_reg.ph   <= ECFG_P_FLAGS;
      r_reg.pend <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign out_lvl       = r_reg.on ? r_reg.flags[`ECFG_B_POL]
                                  : ~r_reg.flags[`ECFG_B_POL];
  assign WAKE_OUT_OE_O = en && (r_reg.flags[`ECFG_B_DRV] || !out_lvl);
  assign WAKE_OUT_O    = en && out_lvl && r_reg.flags[`ECFG_B_DRV];
  assign MEM_ADDR_O    = r_reg.addr;
  assign MEM_RD_O      = r_reg.st == ECFG_S_RD;
  assign REG_RDATA_O   = r_reg.rdata;
  assign FILT_CFG_O    = fword(r_reg.fimg, 0);
  assign FILT_MASK_O   = {fword(r_reg.fimg, 16), fword(r_reg.fimg, 12),
                          fword(r_reg.fimg, 8), fword(r_reg.fimg, 4)};
  assign TEST_BUS_O    = r_reg.tbus;
  assign LOAD_DONE_O   = r_reg.done;
  assign IRQ_O         = |(r_reg.ist & r_reg.imsk);

  // checks
  sequence s_pulse_armed;
    r_reg.on && r_reg.pcnt == (r_reg.flags[`ECFG_B_LEN] ? LONG_LD : SHORT_LD);
  endsequence

  property p_dis;
    @(posedge CLK_I) disable iff (RESET_I) !en |-> !WAKE_OUT_OE_O && !r_reg.on;
  endproperty
  a_dis: assert property (p_dis) else $error("wake driven while disabled");

  property p_evt;
    @(posedge CLK_I) disable iff (RESET_I)
      evt && !r_reg.on && $stable(r_reg.flags) ##1 en |-> r_reg.on;
  endproperty
  a_evt: assert property (p_evt) else $error("event did not assert wake");

  property p_len;
    @(posedge CLK_I) disable iff (RESET_I)
      evt && !r_reg.on && !REG_WR_I |=> s_pulse_armed;
  endproperty
  a_len: assert property (p_len) else $error("pulse length load wrong");

  property p_norestart;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.on && pulse && r_reg.pcnt != {CW{1'b0}} && !REG_WR_I
      |=> r_reg.pcnt == $past(r_reg.pcnt) - CW'(1);
  endproperty
  a_norestart: assert property (p_norestart) else $error("pulse restarted");

  property p_end;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.on && pulse && r_reg.pcnt == {CW{1'b0}} && !REG_WR_I |=> !r_reg.on;
  endproperty
  a_end: assert property (p_end) else $error("pulse did not end");

  property p_level;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.on && !pulse && !REG_WR_I |=> r_reg.on && (r_reg.flags[`ECFG_B_DRV]
      ? WAKE_OUT_O == r_reg.flags[`ECFG_B_POL] : WAKE_OUT_OE_O != r_reg.flags[`ECFG_B_POL]);
  endproperty
  a_level: assert property (p_level) else $error("level dropped");

  property p_pol;
    @(posedge CLK_I) disable iff (RESET_I)
      en && r_reg.flags[`ECFG_B_DRV] |-> WAKE_OUT_O == (r_reg.on == r_reg.flags[`ECFG_B_POL]);
  endproperty
  a_pol: assert property (p_pol) else $error("wake polarity wrong");

  property p_od;
    @(posedge CLK_I) disable iff (RESET_I)
      WAKE_OUT_OE_O && !r_reg.flags[`ECFG_B_DRV] |-> !WAKE_OUT_O;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  property p_filt;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.st == ECFG_S_FILT ##1 r_reg.ph == ECFG_P_FILT && r_reg.st == ECFG_S_RD
      |-> tbl_at(r_reg.tbl, `ECFG_OFF_WUF_LEN) == `ECFG_WUF_LEN;
  endproperty
  a_filt: assert property (p_filt) else $error("filter image length not 20");

  property p_tb;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.st == ECFG_S_TB ##1 r_reg.ph == ECFG_P_TB && r_reg.st == ECFG_S_RD
      |-> tbl_at(r_reg.tbl, `ECFG_OFF_TB_LEN) == `ECFG_TB_LEN;
  endproperty
  a_tb: assert property (p_tb) else $error("test bus length not 4");

  property p_tbl;
    @(posedge CLK_I) disable iff (RESET_I)
      r_reg.st == ECFG_S_CAP && r_reg.ph == ECFG_P_TBL
      |=> r_reg.tbl[$past(r_reg.cnt)] == $past(MEM_DATA_I);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table byte not captured");
endmodule
`default_nettype wire

// [testbench/ecfg_mem_model.sv]
// configuration memory image answering the loader's reads
// assumes one read strobe at a time and data sampled on the next edge
`timescale 1ns/1ps
`default_nettype none
module ecfg_mem_model
#(
  parameter logic [7:0] FLAGS_INIT = 8'h5C
)(
  input  wire logic       clk_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       rd_i,
  output logic [7:0]      data_o
);
  logic [7:0] mem [0:511];

  initial
  begin
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    mem[9'h009] = FLAGS_INIT;
    mem[9'h03D] = 8'h14;
    mem[9'h03E] = 8'h40;
    mem[9'h041] = 8'h04;
    mem[9'h042] = 8'h50;
    for (int i = 0; i < 8; i++)
    begin
      mem[9'h050 + i] = 8'h00;
    end
    for (int i = 0; i < 4; i++)
    begin
      mem[9'h031 + i] = 8'h00;
    end
    mem[9'h03F] = 8'h00;
    mem[9'h040] = 8'h00;
    mem[9'h043] = 8'h00;
    mem[9'h044] = 8'h02;
    mem[9'h045] = 8'h00;
  end

  // data valid one cycle after a strobe, toggling otherwise
  always @(posedge clk_i)
  begin
    if (rd_i)
      data_o <= mem[addr_i];
    else
      data_o <= ~data_o;
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the loader and wake output generator
// drives registers, events and reset; a memory model answers reads
`timescale 1ns/1ps
`default_nettype none
`include "ecfg_cfg.svh"
module testbench;
  logic         clk;
  logic         rst;
  logic [8:0]   mem_addr;
  logic         mem_rd;
  logic [7:0]   mem_data;
  logic [3:0]   r_addr;
  logic [31:0]  r_wdata;
  logic         r_wr;
  logic         r_rd;
  logic [31:0]  r_rdata;
  logic [4:0]   evt;
  logic         w_out;
  logic         w_oe;
  logic [31:0]  fcfg;
  logic [127:0] fmask;
  logic [31:0]  tbus;
  logic         done;
  logic         irq;
  logic [31:0]  v;
  logic [31:0]  cfg0;
  int           num_errors;
  int           comparisons;

  ecfg_loader #(.SHORT_CYC(20), .LONG_CYC(50)) uut (
    .CLK_I(clk), .RESET_I(rst), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd),
    .MEM_DATA_I(mem_data), .REG_ADDR_I(r_addr), .REG_WDATA_I(r_wdata),
    .REG_WR_I(r_wr), .REG_RD_I(r_rd), .REG_RDATA_O(r_rdata),
    .WAKE_PIN_EVT_I(evt[0]), .PACKET_EVT_I(evt[1]), .WAKE_FILTER_EVT_I(evt[2]),
    .DEST_ADDR_MATCH_I(evt[3]), .LINK_CHANGE_EVT_I(evt[4]), .WAKE_OUT_O(w_out),
    .WAKE_OUT_OE_O(w_oe), .FILT_CFG_O(fcfg), .FILT_MASK_O(fmask),
    .TEST_BUS_O(tbus), .LOAD_DONE_O(done), .IRQ_O(irq));

  ecfg_mem_model mem_m (.clk_i(clk), .addr_i(mem_addr), .rd_i(mem_rd), .data_o(mem_data));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    r_addr  <= a;
    r_wdata <= d;
    r_wr    <= 1'b1;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    r_addr <= a;
    r_rd   <= 1'b1;
    @(posedge clk);
    r_rd <= 1'b0;
    #1 v = r_rdata;
  endtask

  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, done}, 32'h1);
  endtask

  function automatic logic [31:0] img_word(input int b);
    return {mem_m.mem[b + 3], mem_m.mem[b + 2], mem_m.mem[b + 1], mem_m.mem[b]};
  endfunction

  // one event, a repeat five cycles later, count cycles at the active pair
  task automatic wake(input logic [7:0] fl, input int src, input int len,
                      input logic ao, input logic aoe, input int exp_n, input logic ist);
    int n = 0;
    wr(`ECFG_R_FLAGS, {24'h0, fl});
    @(posedge clk);
    evt[src] <= 1'b1;
    @(posedge clk);
    evt[src] <= 1'b0;
    for (int k = 0; k < len + 8; k++)
    begin
      #1;
      if (w_out === ao && w_oe === aoe)
        n++;
      @(posedge clk);
      evt[src] <= (k == 3);
    end
    chk(32'(n), 32'(exp_n));
    rd(`ECFG_R_IST);
    chk({31'h0, v[`ECFG_I_WAKE]}, {31'h0, ist});
    wr(`ECFG_R_IST, 32'h4);
  endtask

  initial
  begin
    rst = 1'b1;
    r_addr = 4'h0;
    r_wdata = 32'h0;
    r_wr = 1'b0;
    r_rd = 1'b0;
    evt = 5'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_done();
    rd(`ECFG_R_FLAGS);
    chk(v, 32'h5C);
    rd(4'hD);
    chk(v, 32'h0);
    rd(`ECFG_R_FCFG);
    chk(v, img_word(128));
    chk(fcfg, img_word(128));
    for (int w = 0; w < 4; w++)
    begin
      rd(4'(`ECFG_R_FMSK0 + w));
      chk(v, img_word(132 + 4 * w));
      chk(fmask[32 * w +: 32], img_word(132 + 4 * w));
    end
    rd(`ECFG_R_TBUS);
    chk(v, img_word(160));
    chk(tbus, img_word(160));
    for (int i = 0; i < 44; i++)
    begin
      wr(`ECFG_R_TSEL, 32'(i));
      rd(`ECFG_R_TDATA);
      chk(v, {24'h0, mem_m.mem[9'h02E + i]});
    end
    // done interrupt raised through the mask, then cleared
    rd(`ECFG_R_IST);
    chk(v, 32'h1);
    wr(`ECFG_R_IMSK, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    wr(`ECFG_R_IST, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    wake(8'h7F, 0, 20, 1'b0, 1'b0, 28, 1'b0);
    for (int s = 0; s < 5; s++)
    begin
      wake(8'hDF, s, 20, 1'b1, 1'b1, 20, 1'b1);
    end
    wake(8'hE7, 4, 50, 1'b0, 1'b1, 50, 1'b1);
    wake(8'hDD, 1, 20, 1'b1, 1'b1, 0, 1'b0);
    wake(8'h9F, 2, 30, 1'b1, 1'b1, 38, 1'b1);
    wr(`ECFG_R_CTRL, 32'h2);
    #1 chk({30'h0, w_oe, w_out}, 32'h2);
    // bad filter image length refused on a second load
    mem_m.mem[9'h03D] = 8'h10;
    cfg0 = img_word(128);
    wr(`ECFG_R_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    wait_done();
    rd(`ECFG_R_STATUS);
    chk({31'h0, v[2]}, 32'h1);
    chk(v, 32'h5);
    rd(`ECFG_R_IST);
    chk(v, 32'h3);
    rd(`ECFG_R_FCFG);
    chk(v, cfg0);
    chk(fcfg, cfg0);
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
